/* rtl/port_maint_pkg.sv */
package port_maint_pkg;

  // ****************************************************************
  // widths and sizes
  // ****************************************************************
  localparam int DATA_W     = 8;
  localparam int TRACE_W    = 32;
  localparam int CNT_W      = 24;
  localparam int NUM_TRC    = 2;
  localparam int NUM_CH     = 6;
  localparam int HIST_DEPTH = 16;
  localparam int HIST_AW    = 4;
  localparam int FIFO_DEPTH = 16;

  // ****************************************************************
  // indexes, fill patterns and reset values
  // ****************************************************************
  localparam int TRC_SECTION = 0;
  localparam int TRC_HO_PATH = 1;
  // channel = level * 2 + end; level 0 is the regenerator section
  localparam logic [2:0] CH_RS_FAR = 3'h1;

  localparam logic [DATA_W-1:0] AIS_BYTE  = 8'hff;
  localparam logic [DATA_W-1:0] UNEQ_BYTE = 8'h00;
  localparam logic [3:0]        SSM_DNU   = 4'hf;
  localparam logic [3:0]        SSM_RST   = 4'hf;
  localparam logic [1:0]        TRACE_PERSIST = 2'h3;
  localparam logic [CNT_W-1:0]  CNT_MAX   = 24'hffffff;
  localparam logic [TRACE_W-1:0] TRACE_RST = 32'h00000000;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    LOOP_NONE = 2'b00,
    LOOP_NET  = 2'b01,
    LOOP_CUST = 2'b11
  } loop_e;

  typedef enum logic [1:0] {
    RATE_E1_TRA = 2'b00,
    RATE_E1_PRA = 2'b01,
    RATE_E3_34  = 2'b11,
    RATE_E3_45  = 2'b10
  } rate_e;

  typedef struct packed {
    logic       es;
    logic       ses;
    logic       uas;
    logic [7:0] bbe;
  } perf_evt_s;

  typedef struct packed {
    logic [CNT_W-1:0] es;
    logic [CNT_W-1:0] ses;
    logic [CNT_W-1:0] bbe;
    logic [CNT_W-1:0] uas;
  } perf_cnt_s;

  typedef perf_cnt_s [NUM_CH-1:0] perf_set_t;

  typedef struct packed {
    logic               valid;
    logic [TRACE_W-1:0] id;
  } trace_in_s;

  localparam int HIST_W = $bits(perf_set_t);

endpackage

/* rtl/stream_fifo.sv */
`timescale 1ns/10ps
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  wire              full  = (wrPtr[AW] != rdPtr[AW]) &&
                            (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  wire              empty = (wrPtr == rdPtr);
  wire              push  = inValid && !full;
  wire              pop   = outReady && !empty;

  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = store[rdPtr[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop)  rdPtr <= rdPtr + 1'b1;
    end
  end
endmodule // stream_fifo

/* rtl/hist_mem.sv */
`timescale 1ns/10ps
module hist_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] cells [DEPTH];

  // contents are undefined until written; the host tracks how many
  // intervals have elapsed
  always_ff @(posedge sys_clk) begin
    if (wrEn) cells[wrAddr] <= wrData;
    rdData <= cells[rdAddr];
  end
endmodule // hist_mem

/* rtl/port_maintenance.sv */
`timescale 1ns/10ps
// Summary of operation
// - trace mismatch replaces downstream data with AIS
// - mismatch alarm only when checking enabled
// - send configured trace, hold accepted received trace
// - higher-order trace only with three tributary structure
// - reset disabled; disabled passes nothing, no alarms
// - disabled SDH: unequipped to line, AIS matrixward
// - alarms also need slot alarm gate
// - outgoing quality: internal clock or do-not-use
// - sync source candidate forces do-not-use
// - section near only; others near and far
// - quarter-hour and day current counters per end
// - sixteen quarter-hour history sets plus previous day
// - e1 mode: transparent 2M or primary rate
// - e3 mode: transparent 34M or 45M
// - loop network, customer or none releases
// - primary rate mode rejects management loop requests
// - no loop applied on disabled port
// - enable to disable releases active loop
// - disabled PDH sends AIS both directions
module port_maintenance (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic                         adminEnable,
  input  wire logic                         portIsSdh,
  input  wire logic                         portIsE3,
  input  wire logic                         threeTribStructure,
  input  wire logic                         slotAlarmGate,
  input  wire logic [1:0]                   traceCheckEnable,
  input  wire logic [1:0][31:0]             expectedTraceId,
  input  wire logic [1:0][31:0]             sentTraceId,
  input  wire port_maint_pkg::trace_in_s [1:0] rxTrace,
  output logic      [1:0][31:0]             txTraceId,
  output logic      [1:0][31:0]             capturedTraceId,
  output logic      [1:0]                   timAlarm,
  input  wire logic                         egressQualitySelect,
  input  wire logic [3:0]                   internalClockQuality,
  input  wire logic                         syncSourceCandidate,
  output logic      [3:0]                   egress_quality_select,
  input  wire logic                         e1LineMode,
  input  wire logic                         e3LineMode,
  output port_maint_pkg::rate_e             lineRate,
  input  wire logic                         loopRequest,
  input  wire port_maint_pkg::loop_e        loopbackSelect,
  input  wire logic                         ntLoopRequest,
  input  wire port_maint_pkg::loop_e        ntLoopSelect,
  output port_maint_pkg::loop_e             loopActive,
  output logic                              loopRejected,
  input  wire logic [7:0]                   lineRxData,
  input  wire logic                         lineRxValid,
  output logic                              lineRxReady,
  output logic      [7:0]                   lineTxData,
  output logic                              lineTxValid,
  output logic      [7:0]                   matrixTxData,
  output logic                              matrixTxValid,
  input  wire logic                         matrixTxReady,
  input  wire logic [7:0]                   matrixRxData,
  input  wire logic                         matrixRxValid,
  input  wire logic                         perfSecond,
  input  wire port_maint_pkg::perf_evt_s [5:0] perfEvt,
  input  wire logic                         quarterBoundary,
  input  wire logic                         dayBoundary,
  input  wire logic [2:0]                   perfSel,
  input  wire logic [3:0]                   histSel,
  output port_maint_pkg::perf_cnt_s         quarterCurrentRd,
  output port_maint_pkg::perf_cnt_s         dayCurrentRd,
  output port_maint_pkg::perf_cnt_s         quarterHistoryRd,
  output port_maint_pkg::perf_cnt_s         dayHistoryRd
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [port_maint_pkg::CNT_W-1:0] satAdd(
    input logic [port_maint_pkg::CNT_W-1:0] a,
    input logic [7:0]                       b
  );
    logic [port_maint_pkg::CNT_W:0] s;
    s = {1'b0, a} + {17'h0, b};
    return s[port_maint_pkg::CNT_W] ? port_maint_pkg::CNT_MAX :
           s[port_maint_pkg::CNT_W-1:0];
  endfunction

  function automatic port_maint_pkg::perf_cnt_s addEvt(
    input port_maint_pkg::perf_cnt_s c,
    input port_maint_pkg::perf_evt_s e
  );
    port_maint_pkg::perf_cnt_s r;
    r.es  = satAdd(c.es,  {7'h00, e.es});
    r.ses = satAdd(c.ses, {7'h00, e.ses});
    r.uas = satAdd(c.uas, {7'h00, e.uas});
    r.bbe = satAdd(c.bbe, e.bbe);
    return r;
  endfunction

  function automatic port_maint_pkg::perf_cnt_s pickCh(
    input port_maint_pkg::perf_set_t set,
    input logic [2:0]                idx
  );
    pickCh = '0;
    if (idx < 3'(port_maint_pkg::NUM_CH)) pickCh = set[idx];
  endfunction

  function automatic port_maint_pkg::loop_e cleanLoop(
    input port_maint_pkg::loop_e sel
  );
    case (sel)
      port_maint_pkg::LOOP_NET:  cleanLoop = port_maint_pkg::LOOP_NET;
      port_maint_pkg::LOOP_CUST: cleanLoop = port_maint_pkg::LOOP_CUST;
      default:                   cleanLoop = port_maint_pkg::LOOP_NONE;
    endcase
  endfunction

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // trace identifiers
  // ****************************************************************
  logic [1:0][31:0] traceCand;
  logic [1:0][1:0]  traceRun;
  logic [1:0]       levelOn;
  logic [1:0]       sameId;
  logic [1:0]       timRaw;

  assign levelOn = {threeTribStructure, 1'b1};

  for (genvar i = 0; i < 2; i++) begin : g_trace
    assign sameId[i] = rxTrace[i].id == traceCand[i];
    assign timRaw[i] = traceCheckEnable[i] && levelOn[i] &&
                       (capturedTraceId[i] != expectedTraceId[i]);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      traceCand       <= '0;
      traceRun        <= '0;
      capturedTraceId <= '0;
      txTraceId       <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        txTraceId[i] <= levelOn[i] ? sentTraceId[i] :
                        port_maint_pkg::TRACE_RST;
        if (!levelOn[i]) begin
          traceRun[i]        <= '0;
          capturedTraceId[i] <= port_maint_pkg::TRACE_RST;
        end else if (rxTrace[i].valid) begin
          traceCand[i] <= rxTrace[i].id;
          traceRun[i]  <= !sameId[i] ? 2'h0 :
                          (traceRun[i] == port_maint_pkg::TRACE_PERSIST - 2'h1)
                          ? traceRun[i] : traceRun[i] + 2'h1;
          if (sameId[i] &&
              traceRun[i] >= port_maint_pkg::TRACE_PERSIST - 2'h2)
            capturedTraceId[i] <= rxTrace[i].id;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) timAlarm <= '0;
    else     timAlarm <= timRaw & {2{adminEnable && slotAlarmGate}};
  end

  property p_tim_gate;
    timAlarm[0] |-> $past(traceCheckEnable[0] && adminEnable &&
                          slotAlarmGate);
  endproperty
  a_tim_gate: assert property (p_tim_gate)
    else $error("trace alarm raised without its enables");

  property p_trace_persist;
    (capturedTraceId[0] != $past(capturedTraceId[0])) |->
      $past(rxTrace[0].valid && sameId[0]);
  endproperty
  a_trace_persist: assert property (p_trace_persist)
    else $error("trace accepted without a repeated frame");

  // ****************************************************************
  // traffic paths
  // ****************************************************************
  logic       fifoInValid;
  logic       fifoInReady;
  logic [7:0] fifoInData;
  wire        loopNet  = loopActive == port_maint_pkg::LOOP_NET;
  wire        loopCust = loopActive == port_maint_pkg::LOOP_CUST;
  wire        timDown  = |timRaw;
  wire        sendAis  = !adminEnable || timDown;

  assign fifoInValid = loopCust ? matrixRxValid : lineRxValid;
  assign fifoInData  = sendAis ? port_maint_pkg::AIS_BYTE :
                       loopCust ? matrixRxData : lineRxData;
  // looped-away line data is consumed and dropped, so no stall there
  assign lineRxReady = loopCust ? 1'b1 : fifoInReady;

  stream_fifo #(
    .WIDTH (port_maint_pkg::DATA_W),
    .DEPTH (port_maint_pkg::FIFO_DEPTH)
  ) u_down_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (matrixTxValid),
    .outReady (matrixTxReady),
    .outData  (matrixTxData)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lineTxData  <= port_maint_pkg::UNEQ_BYTE;
      lineTxValid <= 1'b0;
    end else begin
      if (!adminEnable)
        lineTxData <= portIsSdh ? port_maint_pkg::UNEQ_BYTE :
                      port_maint_pkg::AIS_BYTE;
      else if (loopNet)
        lineTxData <= lineRxData;
      else
        lineTxData <= matrixRxData;
      lineTxValid <= loopNet ? (lineRxValid && lineRxReady) : matrixRxValid;
    end
  end

  property p_ais_down;
    (traceCheckEnable[0] && capturedTraceId[0] != expectedTraceId[0] &&
     fifoInValid) |-> fifoInData == port_maint_pkg::AIS_BYTE;
  endproperty
  a_ais_down: assert property (p_ais_down)
    else $error("mismatched trace did not force ais downstream");

  property p_sdh_uneq;
    (!adminEnable && portIsSdh) |=> lineTxData == port_maint_pkg::UNEQ_BYTE;
  endproperty
  a_sdh_uneq: assert property (p_sdh_uneq)
    else $error("disabled sdh port not sending unequipped");

  // ****************************************************************
  // synchronization status and line mode
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      egress_quality_select <= port_maint_pkg::SSM_RST;
      lineRate  <= port_maint_pkg::RATE_E1_TRA;
    end else begin
      egress_quality_select <= (syncSourceCandidate || !egressQualitySelect) ?
                   port_maint_pkg::SSM_DNU : internalClockQuality;
      lineRate  <= portIsE3 ?
                   (e3LineMode ? port_maint_pkg::RATE_E3_45 :
                                 port_maint_pkg::RATE_E3_34) :
                   (e1LineMode ? port_maint_pkg::RATE_E1_PRA :
                                 port_maint_pkg::RATE_E1_TRA);
    end
  end

  property p_ssm_dnu;
    syncSourceCandidate |=> egress_quality_select == port_maint_pkg::SSM_DNU;
  endproperty
  a_ssm_dnu: assert property (p_ssm_dnu)
    else $error("sync candidate port not signalling do-not-use");

  // ****************************************************************
  // loopbacks
  // ****************************************************************
  port_maint_pkg::loop_e next_loop;
  logic                  adminQ;
  wire praMode   = !portIsE3 && e1LineMode;
  wire pdhPort   = !portIsSdh;
  wire mgmtOk    = loopRequest && pdhPort && !praMode &&
    (adminEnable || loopbackSelect == port_maint_pkg::LOOP_NONE);
  wire ntOk      = ntLoopRequest && pdhPort && praMode &&
    (adminEnable || ntLoopSelect == port_maint_pkg::LOOP_NONE);
  wire adminFell = adminQ && !adminEnable;

  assign next_loop = (adminFell || !adminEnable) ? port_maint_pkg::LOOP_NONE :
                     mgmtOk ? cleanLoop(loopbackSelect) :
                     ntOk   ? cleanLoop(ntLoopSelect) : loopActive;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      adminQ       <= 1'b0;
      loopActive   <= port_maint_pkg::LOOP_NONE;
      loopRejected <= 1'b0;
    end else begin
      adminQ       <= adminEnable;
      loopActive   <= next_loop;
      loopRejected <= loopRequest && !mgmtOk;
    end
  end

  property p_pra_reject;
    (loopRequest && praMode) |=> loopRejected;
  endproperty
  a_pra_reject: assert property (p_pra_reject)
    else $error("loop request accepted in primary rate mode");

  property p_disabled_noloop;
    !adminEnable |=> loopActive == port_maint_pkg::LOOP_NONE;
  endproperty
  a_disabled_noloop: assert property (p_disabled_noloop)
    else $error("loop active on a disabled port");

  property p_loop_release;
    (mgmtOk && adminEnable && loopbackSelect == port_maint_pkg::LOOP_NONE)
      |=> loopActive == port_maint_pkg::LOOP_NONE;
  endproperty
  a_loop_release: assert property (p_loop_release)
    else $error("loop none did not release the loop");

  // ****************************************************************
  // performance counters
  // ****************************************************************
  port_maint_pkg::perf_set_t quarterCur;
  port_maint_pkg::perf_set_t dayCur;
  port_maint_pkg::perf_set_t next_quarter;
  port_maint_pkg::perf_set_t next_day;
  port_maint_pkg::perf_set_t dayHist;
  logic [port_maint_pkg::HIST_W-1:0] histWord;
  logic [3:0]                        histWrPtr;
  wire  [3:0] histRdAddr = histWrPtr - 4'h1 - histSel;

  always_comb begin
    for (int c = 0; c < port_maint_pkg::NUM_CH; c++) begin
      next_quarter[c] = quarterBoundary ? '0 : quarterCur[c];
      next_day[c]     = dayBoundary ? '0 : dayCur[c];
      if (perfSecond && 3'(c) != port_maint_pkg::CH_RS_FAR) begin
        next_quarter[c] = addEvt(next_quarter[c], perfEvt[c]);
        next_day[c]     = addEvt(next_day[c], perfEvt[c]);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      quarterCur       <= '0;
      dayCur           <= '0;
      dayHist          <= '0;
      histWrPtr        <= '0;
      quarterCurrentRd <= '0;
      dayCurrentRd     <= '0;
      quarterHistoryRd <= '0;
      dayHistoryRd     <= '0;
    end else begin
      quarterCur <= next_quarter;
      dayCur     <= next_day;
      if (dayBoundary)     dayHist   <= dayCur;
      if (quarterBoundary) histWrPtr <= histWrPtr + 4'h1;
      quarterCurrentRd <= pickCh(quarterCur, perfSel);
      dayCurrentRd     <= pickCh(dayCur, perfSel);
      quarterHistoryRd <= pickCh(port_maint_pkg::perf_set_t'(histWord),
                                 perfSel);
      dayHistoryRd     <= pickCh(dayHist, perfSel);
    end
  end

  hist_mem #(
    .WIDTH (port_maint_pkg::HIST_W),
    .DEPTH (port_maint_pkg::HIST_DEPTH),
    .AW    (port_maint_pkg::HIST_AW)
  ) u_quarter_hist (
    .sys_clk (sys_clk),
    .wrEn    (quarterBoundary),
    .wrAddr  (histWrPtr),
    .wrData  (quarterCur),
    .rdAddr  (histRdAddr),
    .rdData  (histWord)
  );

  property p_rs_far_idle;
    1'b1 |-> quarterCur[1] == '0 && dayCur[1] == '0;
  endproperty
  a_rs_far_idle: assert property (p_rs_far_idle)
    else $error("section far end counter moved");

  property p_quarter_clear;
    (quarterBoundary && !perfSecond) |=> quarterCur[0] == '0;
  endproperty
  a_quarter_clear: assert property (p_quarter_clear)
    else $error("quarter counters not cleared at boundary");

endmodule // port_maintenance

/* dv/line_partner.sv */
`timescale 1ns/10ps
// ********
// remote line equipment
// ********
module line_partner (
  input  wire logic                   sys_clk,
  input  wire logic                   lineRxReady,
  output logic [7:0]                  lineRxData,
  output logic                        lineRxValid,
  output port_maint_pkg::trace_in_s [1:0] rxTrace
);
  initial begin
    lineRxValid = 0;
    lineRxData = 8'h00;
    rxTrace = '0;
  end
  // ready is looked at on the falling edge, where it cannot race the push
  task automatic send_byte(input logic [7:0] d);
    @(negedge sys_clk);
    lineRxValid = 1;
    lineRxData = d;
    while (lineRxReady !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  // idle data is inverted so a stale word never looks valid
  task automatic rest();
    @(negedge sys_clk);
    lineRxValid = 0;
    lineRxData = ~lineRxData;
  endtask
  task automatic send_trace(input int i, input logic [31:0] id);
    @(negedge sys_clk);
    rxTrace[i].valid = 1;
    rxTrace[i].id = id;
    @(negedge sys_clk);
    rxTrace[i].valid = 0;
    rxTrace[i].id = ~id;
  endtask
endmodule // line_partner

/* dv/port_maintenance_tb.sv */
`timescale 1ns/10ps
module port_maintenance_tb;
  // ********
  // signals
  // ********
  localparam port_maint_pkg::loop_e NONE = port_maint_pkg::LOOP_NONE;
  localparam port_maint_pkg::loop_e NET = port_maint_pkg::LOOP_NET;
  localparam port_maint_pkg::loop_e CUST = port_maint_pkg::LOOP_CUST;
  localparam logic [95:0] SET3 = {24'h1, 24'h1, 24'h7, 24'h1};
  logic sys_clk = 0, rst = 1, adminEnable = 0, portIsSdh = 0;
  logic portIsE3 = 0, threeTribStructure = 0, slotAlarmGate = 0;
  logic egressQualitySelect = 0, syncSourceCandidate = 0;
  logic e1LineMode = 0, e3LineMode = 0, loopRequest = 0;
  logic ntLoopRequest = 0, matrixTxReady = 0, matrixRxValid = 0;
  logic perfSecond = 0, quarterBoundary = 0, dayBoundary = 0;
  logic loopRejected, lineRxValid, lineRxReady, lineTxValid;
  logic matrixTxValid;
  logic [1:0] traceCheckEnable = 2'h0, timAlarm;
  logic [1:0][31:0] expectedTraceId = '0, sentTraceId = '0;
  logic [1:0][31:0] txTraceId, capturedTraceId;
  logic [3:0] internalClockQuality = 4'h0, histSel = 4'h0, egress_quality_select;
  logic [2:0] perfSel = 3'h0;
  logic [7:0] matrixRxData = 8'h00, lineRxData, lineTxData, matrixTxData;
  port_maint_pkg::trace_in_s [1:0] rxTrace;
  port_maint_pkg::rate_e lineRate;
  port_maint_pkg::rate_e rates [4] = '{port_maint_pkg::RATE_E1_TRA,
    port_maint_pkg::RATE_E1_PRA, port_maint_pkg::RATE_E3_34,
    port_maint_pkg::RATE_E3_45};
  port_maint_pkg::loop_e loopbackSelect = NONE, ntLoopSelect = NONE;
  port_maint_pkg::loop_e loopActive;
  port_maint_pkg::perf_evt_s [5:0] perfEvt = '0;
  port_maint_pkg::perf_cnt_s quarterCurrentRd, dayCurrentRd;
  port_maint_pkg::perf_cnt_s quarterHistoryRd, dayHistoryRd;
  int nFail = 0, totalChecks = 0, cycles = 0;

  always #20 sys_clk = ~sys_clk;

  port_maintenance dut (
    .sys_clk, .rst, .adminEnable, .portIsSdh, .portIsE3,
    .threeTribStructure, .slotAlarmGate, .traceCheckEnable,
    .expectedTraceId, .sentTraceId, .rxTrace, .txTraceId,
    .capturedTraceId, .timAlarm, .egressQualitySelect,
    .internalClockQuality, .syncSourceCandidate, .egress_quality_select,
    .e1LineMode, .e3LineMode, .lineRate, .loopRequest,
    .loopbackSelect, .ntLoopRequest, .ntLoopSelect, .loopActive,
    .loopRejected, .lineRxData, .lineRxValid, .lineRxReady,
    .lineTxData, .lineTxValid, .matrixTxData, .matrixTxValid,
    .matrixTxReady, .matrixRxData, .matrixRxValid, .perfSecond,
    .perfEvt, .quarterBoundary, .dayBoundary, .perfSel, .histSel,
    .quarterCurrentRd, .dayCurrentRd, .quarterHistoryRd, .dayHistoryRd
  );
  line_partner far (.sys_clk, .lineRxReady, .lineRxData, .lineRxValid,
    .rxTrace);

  // ********
  // tasks
  // ********
  task automatic tick(input int n = 1);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic testDone();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ready stays high, so each word shows for one cycle only
  task automatic pop(input logic [7:0] exp);
    int i;
    i = 0;
    while (matrixTxValid !== 1'b1 && i < 8) begin
      tick();
      i++;
    end
    chk(matrixTxValid, 1'b1);
    chk(matrixTxData, exp);
    tick();
  endtask
  task automatic lreq(input port_maint_pkg::loop_e s, input logic nt,
                      input port_maint_pkg::loop_e act, input logic rej);
    loopRequest = !nt;
    ntLoopRequest = nt;
    loopbackSelect = s;
    ntLoopSelect = s;
    tick();
    chk(loopActive, act);
    chk(loopRejected, rej);
    loopRequest = 0;
    ntLoopRequest = 0;
    tick();
  endtask

  // the whole sequence needs about 130 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      nFail++;
      testDone();
    end
  end

  initial begin
    tick(12);
    chk(egress_quality_select, port_maint_pkg::SSM_RST);
    chk(loopActive, NONE);
    chk(matrixTxValid, 0);
    rst = 0;
    matrixTxReady = 1;
    traceCheckEnable = 2'h1;
    slotAlarmGate = 1;
    expectedTraceId[0] = 32'hc0de0001;
    matrixRxValid = 1;
    matrixRxData = 8'h3c;
    tick(2);
    chk(timAlarm, 2'h0);
    chk(lineTxData, port_maint_pkg::AIS_BYTE);
    portIsSdh = 1;
    tick(2);
    chk(lineTxData, port_maint_pkg::UNEQ_BYTE);
    far.send_byte(8'h5a);
    far.rest();
    pop(port_maint_pkg::AIS_BYTE);
    adminEnable = 1;
    portIsSdh = 0;
    tick(2);
    chk(timAlarm, 2'h1);
    chk(lineTxData, 8'h3c);
    chk(lineTxValid, 1'b1);
    matrixRxValid = 0;
    slotAlarmGate = 0;
    tick(2);
    chk(timAlarm, 2'h0);
    chk(lineTxValid, 1'b0);
    slotAlarmGate = 1;
    far.send_byte(8'h66);
    far.rest();
    pop(port_maint_pkg::AIS_BYTE);
    far.send_trace(0, 32'hc0de0001);
    far.send_trace(0, 32'hc0de0001);
    tick(2);
    chk(timAlarm, 2'h1);
    far.send_trace(0, 32'hc0de0001);
    tick(2);
    chk(capturedTraceId[0], 32'hc0de0001);
    chk(timAlarm, 2'h0);
    sentTraceId = {32'h11112222, 32'h33334444};
    tick(2);
    chk(txTraceId, {32'h0, 32'h33334444});
    threeTribStructure = 1;
    tick(2);
    chk(txTraceId, sentTraceId);
    matrixTxReady = 0;
    for (int i = 0; i < 16; i++) begin
      far.send_byte(8'(i));
    end
    far.rest();
    chk(lineRxReady, 0);
    matrixTxReady = 1;
    for (int i = 0; i < 16; i++) begin
      pop(8'(i));
    end
    chk(matrixTxValid, 0);
    egressQualitySelect = 1;
    internalClockQuality = 4'h2;
    tick(2);
    chk(egress_quality_select, 4'h2);
    syncSourceCandidate = 1;
    tick(2);
    chk(egress_quality_select, port_maint_pkg::SSM_DNU);
    syncSourceCandidate = 0;
    egressQualitySelect = 0;
    tick(2);
    chk(egress_quality_select, port_maint_pkg::SSM_DNU);
    for (int i = 0; i < 4; i++) begin
      {portIsE3, e1LineMode} = 2'(i);
      e3LineMode = e1LineMode;
      tick(2);
      chk(lineRate, rates[i]);
    end
    {portIsE3, e1LineMode, e3LineMode} = 3'h0;
    tick(2);
    lreq(NET, 0, NET, 0);
    lreq(CUST, 0, CUST, 0);
    // customer loop turns matrix words back toward the matrix
    matrixRxValid = 1;
    matrixRxData = 8'h77;
    tick();
    matrixRxValid = 0;
    pop(8'h77);
    lreq(NONE, 0, NONE, 0);
    e1LineMode = 1;
    tick(2);
    lreq(NET, 0, NONE, 1);
    lreq(NET, 1, NET, 0);
    lreq(NONE, 0, NET, 1);
    lreq(NONE, 1, NONE, 0);
    e1LineMode = 0;
    tick(2);
    lreq(NET, 0, NET, 0);
    far.send_byte(8'h99);
    far.rest();
    chk(lineTxData, 8'h99);
    chk(lineTxValid, 1'b1);
    adminEnable = 0;
    tick(2);
    chk(loopActive, NONE);
    lreq(CUST, 0, NONE, 1);
    adminEnable = 1;
    perfEvt[0] = '{1'b1, 1'b0, 1'b0, 8'h05};
    perfEvt[1] = perfEvt[0];
    perfEvt[3] = '{1'b1, 1'b1, 1'b1, 8'h07};
    perfSecond = 1;
    tick();
    perfSecond = 0;
    perfEvt = '0;
    tick(2);
    chk(quarterCurrentRd, {24'h1, 24'h0, 24'h5, 24'h0});
    perfSel = port_maint_pkg::CH_RS_FAR;
    tick(2);
    chk(quarterCurrentRd, 96'h0);
    perfSel = 3'h3;
    tick(2);
    chk(quarterCurrentRd, SET3);
    chk(dayCurrentRd, SET3);
    quarterBoundary = 1;
    tick();
    quarterBoundary = 0;
    tick(3);
    chk(quarterCurrentRd, 96'h0);
    chk(quarterHistoryRd, SET3);
    dayBoundary = 1;
    tick();
    dayBoundary = 0;
    tick(3);
    chk(dayHistoryRd, SET3);
    chk(dayCurrentRd, 96'h0);
    testDone();
  end
endmodule // port_maintenance_tb
